/* pkg/psda_defs.vh */
// Purpose: shared constants for the program space data access bridge
// Assumes: 32-bit APB data, word-aligned registers
// Notes:   offsets are byte addresses
`ifndef PSDA_DEFS_VH
`define PSDA_DEFS_VH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define PSDA_OFF_TBLPG   12'h000
`define PSDA_OFF_RDPG    12'h004
`define PSDA_OFF_WRPG    12'h008
`define PSDA_OFF_STATUS  12'h00C
`define PSDA_OFF_ADDRCNT 12'h010
`define PSDA_RST_TBLPG   8'h00
`define PSDA_RST_RDPG    10'h000
`define PSDA_RST_WRPG    10'h000
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PSDA_TBL_CFG_BIT 7
`define PSDA_RD_EN_BIT   9
`define PSDA_RD_UP_BIT   8
`define PSDA_EA_MSB      15
// ---------------------------------------------------------------
// operation codes on the request port
// ---------------------------------------------------------------
`define PSDA_OP_DATA     3'h0
`define PSDA_OP_RDL      3'h1
`define PSDA_OP_RDH      3'h2
`define PSDA_OP_WTL      3'h3
`define PSDA_OP_WTH      3'h4
// ---------------------------------------------------------------
// extra cycle costs
// ---------------------------------------------------------------
`define PSDA_XTRA_MOV    2'h1
`define PSDA_XTRA_OTHER  2'h2
`define PSDA_XTRA_FAST   2'h0
`define PSDA_PC_STEP     24'h000002
`endif

/* verilog/psda_apb_regs.v */
// Purpose: APB slave holding the page registers and status
// Assumes: single mclk domain, zero wait state
// Notes:   unmapped addresses read zero with pslverr
`timescale 1ns/1ps
`include "psda_defs.vh"
module psda_apb_regs (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [31:0] status_in,
  input  wire [31:0] count_in,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [7:0]  table_page_select,
  output reg  [9:0]  window_read_page,
  output reg  [9:0]  window_write_page
);
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      table_page_select <= `PSDA_RST_TBLPG;
      window_read_page  <= `PSDA_RST_RDPG;
      window_write_page <= `PSDA_RST_WRPG;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup) begin
        case (paddr)
          `PSDA_OFF_TBLPG:   prdata <= {24'h000000, table_page_select};
          `PSDA_OFF_RDPG:    prdata <= {22'h000000, window_read_page};
          `PSDA_OFF_WRPG:    prdata <= {22'h000000, window_write_page};
          `PSDA_OFF_STATUS:  prdata <= status_in;
          `PSDA_OFF_ADDRCNT: prdata <= count_in;
          default:           pslverr <= 1'b1;
        endcase
      end
      // writes land at the edge where the master sees pready high
      if (access & pwrite) begin
        case (paddr)
          `PSDA_OFF_TBLPG: table_page_select <= pwdata[7:0];
          `PSDA_OFF_RDPG:  window_read_page  <= pwdata[9:0];
          `PSDA_OFF_WRPG:  window_write_page <= pwdata[9:0];
          default:         table_page_select <= table_page_select;
        endcase
      end
    end
  end
endmodule

/* verilog/psda_cost.v */
// Purpose: extra cycle cost of a window access
// Assumes: repeat state flags come from the pipeline on mclk
// Notes:   registered result, one cycle latency
`timescale 1ns/1ps
`include "psda_defs.vh"
module psda_cost (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       go,
  input  wire       window_hit,
  input  wire       is_mov,
  input  wire       in_repeat,
  input  wire       rpt_first,
  input  wire       rpt_last,
  input  wire       rpt_irq_exit,
  input  wire       rpt_reentry,
  output reg  [1:0] extra_cycles
);
  reg [1:0] next_extra;
  always @* begin
    next_extra = `PSDA_XTRA_FAST;
    if (window_hit) begin
      if (!in_repeat)
        next_extra = is_mov ? `PSDA_XTRA_MOV : `PSDA_XTRA_OTHER;
      else if (rpt_first | rpt_last | rpt_irq_exit | rpt_reentry)
        next_extra = `PSDA_XTRA_OTHER;
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      extra_cycles <= `PSDA_XTRA_FAST;
    else if (go)
      extra_cycles <= next_extra;
  end
endmodule

/* verilog/psda_top.v */
// Purpose: program space data access bridge for a 16-bit core
// Assumes: pipeline and flash share mclk; flash answers one cycle later
// Notes:   one request in flight; req is ignored while busy
`timescale 1ns/1ps
`include "psda_defs.vh"
module psda_top (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        req,
  input  wire [2:0]  op,
  input  wire        byte_mode,
  input  wire        is_write,
  input  wire [15:0] effective_address,
  input  wire [15:0] wdata,
  input  wire        is_mov,
  input  wire        in_repeat,
  input  wire        rpt_first,
  input  wire        rpt_last,
  input  wire        rpt_irq_exit,
  input  wire        rpt_reentry,
  input  wire [23:0] pc,
  output reg  [23:0] pc_next,
  output reg         done,
  output reg  [15:0] rdata,
  output reg         addr_trap,
  output reg         data_sel,
  output wire [1:0]  extra_cycles,
  output reg         flash_req,
  output reg         flash_we,
  output reg         flash_cfg,
  output reg  [23:0] flash_addr,
  output reg  [2:0]  flash_be,
  output reg  [23:0] flash_wdata,
  input  wire [23:0] flash_rdata,
  output reg         dmem_req,
  output reg  [15:0] dmem_addr
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DATA = 2'b10;

  wire [7:0]  table_page_select;
  wire [9:0]  window_read_page;
  wire [9:0]  window_write_page;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [2:0]  held_op;
  reg         held_byte;
  reg         held_sel;
  reg         held_up;
  reg  [15:0] trap_count;
  reg  [15:0] access_count;
  reg         last_trap;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire tbl_op   = (op != `PSDA_OP_DATA);
  wire tbl_wr   = (op == `PSDA_OP_WTL) | (op == `PSDA_OP_WTH);
  wire tbl_cfg  = table_page_select[`PSDA_TBL_CFG_BIT];
  wire ea_hi    = effective_address[`PSDA_EA_MSB];
  wire win_hit  = ~tbl_op & ea_hi &
                  window_read_page[`PSDA_RD_EN_BIT] & ~is_write;
  wire [9:0] page_used = is_write ? window_write_page : window_read_page;
  wire bad_page = ~tbl_op & ea_hi & (page_used == 10'h000);
  // writes into the window go nowhere: read only view
  wire win_wr   = ~tbl_op & ea_hi & is_write &
                  window_read_page[`PSDA_RD_EN_BIT];
  wire go       = req & (state == ST_IDLE);

  // bit 0 is the byte select, not part of the word address
  function [23:0] win_addr;
    input [9:0]  page;
    input [15:0] ea;
    begin
      win_addr = {1'b0, page[7:0], ea[14:0]};
    end
  endfunction

  // pick one byte of a word by select bit
  function [7:0] pick_byte;
    input [15:0] w;
    input        sel;
    begin
      pick_byte = sel ? w[15:8] : w[7:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // registers and cost
  // ---------------------------------------------------------------
  psda_apb_regs u_regs (
    .mclk              (mclk),
    .arst_n            (arst_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .status_in         ({15'h0000, last_trap, trap_count}),
    .count_in          ({16'h0000, access_count}),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .table_page_select (table_page_select),
    .window_read_page  (window_read_page),
    .window_write_page (window_write_page)
  );

  psda_cost u_cost (
    .mclk         (mclk),
    .arst_n       (arst_n),
    .go           (go),
    .window_hit   (win_hit),
    .is_mov       (is_mov),
    .in_repeat    (in_repeat),
    .rpt_first    (rpt_first),
    .rpt_last     (rpt_last),
    .rpt_irq_exit (rpt_irq_exit),
    .rpt_reentry  (rpt_reentry),
    .extra_cycles (extra_cycles)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req) begin
          if (bad_page | win_wr | (tbl_wr & tbl_cfg))
            next_state = ST_IDLE;
          else if (tbl_op & ~tbl_wr)
            next_state = ST_WAIT;
          else if (win_hit)
            next_state = ST_WAIT;
          else
            next_state = ST_IDLE;
        end
      end
      ST_WAIT: next_state = ST_DATA;
      ST_DATA: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= ST_IDLE;
      held_op      <= `PSDA_OP_DATA;
      held_byte    <= 1'b0;
      held_sel     <= 1'b0;
      held_up      <= 1'b0;
      pc_next      <= 24'h000000;
      done         <= 1'b0;
      rdata        <= 16'h0000;
      addr_trap    <= 1'b0;
      data_sel     <= 1'b0;
      flash_req    <= 1'b0;
      flash_we     <= 1'b0;
      flash_cfg    <= 1'b0;
      flash_addr   <= 24'h000000;
      flash_be     <= 3'h0;
      flash_wdata  <= 24'h000000;
      dmem_req     <= 1'b0;
      dmem_addr    <= 16'h0000;
      trap_count   <= 16'h0000;
      access_count <= 16'h0000;
      last_trap    <= 1'b0;
    end else begin
      state     <= next_state;
      pc_next   <= pc + `PSDA_PC_STEP;
      done      <= 1'b0;
      addr_trap <= 1'b0;
      flash_req <= 1'b0;
      flash_we  <= 1'b0;
      dmem_req  <= 1'b0;
      if (go) begin
        held_op   <= op;
        held_byte <= byte_mode;
        held_sel  <= effective_address[0];
        held_up   <= window_read_page[`PSDA_RD_UP_BIT];
        data_sel  <= 1'b0;
        if (bad_page) begin
          addr_trap  <= 1'b1;
          done       <= 1'b1;
          last_trap  <= 1'b1;
          trap_count <= trap_count + 16'h0001;
        end else if (tbl_op) begin
          last_trap  <= 1'b0;
          flash_cfg  <= tbl_cfg;
          flash_addr <= {table_page_select, effective_address};
          if (tbl_wr) begin
            done <= 1'b1;
            if (!tbl_cfg) begin
              flash_req    <= 1'b1;
              flash_we     <= 1'b1;
              access_count <= access_count + 16'h0001;
              if (op == `PSDA_OP_WTH) begin
                flash_be    <= 3'b100;
                flash_wdata <= {wdata[7:0], 16'h0000};
              end else if (byte_mode) begin
                flash_be    <= effective_address[0] ? 3'b010 : 3'b001;
                flash_wdata <= {8'h00, wdata[7:0], wdata[7:0]};
              end else begin
                flash_be    <= 3'b011;
                flash_wdata <= {8'h00, wdata};
              end
            end
          end else begin
            flash_req    <= 1'b1;
            access_count <= access_count + 16'h0001;
          end
        end else if (win_hit) begin
          last_trap    <= 1'b0;
          flash_req    <= 1'b1;
          flash_cfg    <= 1'b0;
          flash_addr   <= win_addr(window_read_page, effective_address);
          access_count <= access_count + 16'h0001;
        end else if (win_wr) begin
          done      <= 1'b1; // window writes dropped
          last_trap <= 1'b0;
        end else begin
          last_trap <= 1'b0;
          dmem_req  <= 1'b1;
          dmem_addr <= effective_address;
          data_sel  <= 1'b1;
          done      <= 1'b1;
        end
      end
      if (state == ST_DATA) begin
        done <= 1'b1;
        case (held_op)
          `PSDA_OP_RDL: begin
            if (held_byte)
              rdata <= {8'h00,
                        pick_byte(flash_rdata[15:0], held_sel)};
            else
              rdata <= flash_rdata[15:0];
          end
          `PSDA_OP_RDH: begin
            if (held_byte & held_sel)
              rdata <= 16'h0000;
            else
              rdata <= {8'h00, flash_rdata[23:16]};
          end
          default: begin
            if (held_up)
              rdata <= {8'h00, flash_rdata[23:16]};
            else
              rdata <= flash_rdata[15:0];
          end
        endcase
      end
    end
  end
endmodule

/* test/psda_props.sv */
// Purpose: port assertions for the program space bridge
// Assumes: one mclk domain, pages mirrored from apb access phase writes
// Notes:   busy mirror only tracks requests spaced as the bench does
`timescale 1ns/1ps
`include "psda_defs.vh"
module psda_props (
  input wire        mclk,
  input wire        arst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        req,
  input wire [2:0]  op,
  input wire        is_write,
  input wire [15:0] effective_address,
  input wire        is_mov,
  input wire        in_repeat,
  input wire        rpt_first,
  input wire        rpt_last,
  input wire        rpt_irq_exit,
  input wire        rpt_reentry,
  input wire [23:0] pc,
  input wire [23:0] pc_next,
  input wire        done,
  input wire        addr_trap,
  input wire [1:0]  extra_cycles,
  input wire        flash_req,
  input wire        flash_we,
  input wire        flash_cfg,
  input wire [23:0] flash_addr,
  input wire        dmem_req,
  input wire [15:0] dmem_addr
);
  reg  [7:0]  tp;
  reg  [9:0]  rp;
  reg  [9:0]  wp;
  reg  [15:0] ea_q;
  reg         bsy;
  reg  [1:0]  age;
  wire [15:0] ea   = effective_address;
  wire        tk   = req && !bsy;
  wire        dat  = tk && op == `PSDA_OP_DATA;
  wire        win  = dat && ea[15] && rp[9];
  wire        wt   = tk && (op == `PSDA_OP_WTL || op == `PSDA_OP_WTH);
  wire        rd   = tk && (op == `PSDA_OP_RDL || op == `PSDA_OP_RDH);
  wire        edg  = rpt_first | rpt_last | rpt_irq_exit | rpt_reentry;
  wire [1:0]  cost = !in_repeat ? (is_mov ? 2'h1 : 2'h2)
                                : (edg ? 2'h2 : 2'h0);
  wire        wrap = psel && penable && pready && pwrite;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tp <= 8'h00;
      rp <= 10'h000;
      wp <= 10'h000;
      ea_q <= 16'h0000;
      bsy <= 1'b0;
      age <= 2'h0;
    end else begin
      if (wrap && paddr == `PSDA_OFF_TBLPG) tp <= pwdata[7:0];
      if (wrap && paddr == `PSDA_OFF_RDPG) rp <= pwdata[9:0];
      if (wrap && paddr == `PSDA_OFF_WRPG) wp <= pwdata[9:0];
      ea_q <= ea;
      bsy <= done ? 1'b0 : (req ? 1'b1 : bsy);
      if (age != 2'h3) age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_pc_step:
    assert property (age == 2'h3 |-> pc_next == $past(pc) + 24'h000002)
    else $error("pc_next is not pc plus two");
  a_tbl_read:
    assert property (rd |=> flash_req && !flash_we && flash_cfg == tp[7]
      && flash_addr[23:1] == {tp, ea_q[15:1]} ##2 done)
    else $error("table read address or timing wrong");
  a_win_read:
    assert property (win && !is_write |=> flash_req
      && flash_addr == {1'b0, rp[7:0], ea_q[14:0]} ##2 done && !addr_trap)
    else $error("window read address or timing wrong");
  a_win_cost:
    assert property (win && !is_write |=> extra_cycles == $past(cost))
    else $error("window extra cycle count wrong");
  a_data_bypass:
    assert property (dat && !ea[15] |=> done && dmem_req && !flash_req
      && dmem_addr == ea_q && extra_cycles == 2'h0)
    else $error("low data access not sent to data memory");
  a_win_ro:
    assert property (win && is_write && wp != 10'h000
      |=> done && !flash_req && !flash_we && !addr_trap)
    else $error("window write reached flash");
  a_trap_zero:
    assert property (dat && ea[15] && (is_write ? wp : rp) == 10'h000
      |=> done && addr_trap && !flash_req)
    else $error("zero page high access did not trap");
  a_cfg_drop:
    assert property (wt && tp[7] |=> done && !flash_req && !flash_we)
    else $error("configuration write was performed");
  a_tbl_write:
    assert property (wt && !tp[7] |=> flash_we && done
      && flash_addr[23:1] == {tp, ea_q[15:1]})
    else $error("table write not issued");
  a_apb_resp:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not a single pulse");
  a_apb_err:
    assert property (psel && !penable && paddr > 12'h010
      |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped apb access not refused");
  c_win: cover property (win && !is_write);
  c_trap: cover property (done && addr_trap);
  c_cfg: cover property (wt && tp[7]);
endmodule
bind psda_top psda_props u_props (.*);

/* test/psda_flash_model.sv */
// Purpose: behavioural program flash behind the bridge
// Assumes: read data valid only the cycle after a read request
// Notes:   data inverts afterwards so stale sampling shows up
`timescale 1ns/1ps
module psda_flash_model (
  input  wire        mclk,
  input  wire        flash_req,
  input  wire        flash_we,
  input  wire [23:0] flash_addr,
  input  wire [2:0]  flash_be,
  input  wire [23:0] flash_wdata,
  output reg  [23:0] flash_rdata
);
  logic [23:0] mem [bit [23:0]];
  logic [23:0] w;
  logic [23:0] k;
  initial flash_rdata = 24'h000000;
  always @(posedge mclk) begin
    k = {flash_addr[23:1], 1'b0};
    w = mem.exists(k) ? mem[k] : k ^ {k[15:0], k[23:16]} ^ 24'h5A3C96;
    if (flash_we) begin
      for (int i = 0; i < 3; i++)
        if (flash_be[i]) w[8*i+:8] = flash_wdata[8*i+:8];
      mem[k] = w;
    end
    flash_rdata <= (flash_req && !flash_we) ? w : ~flash_rdata;
  end
endmodule

/* test/program_space_data_access_tb.sv */
// Purpose: self-checking bench for the program space bridge
// Assumes: done pulse ends every request, apb answers with pready
// Notes:   rdata masked on requests that return no read data
`timescale 1ns/1ps
`include "psda_defs.vh"
`define CHK(o, x) begin \
  checks++; \
  if ((o) !== (x)) begin \
    num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (o), (x)); \
  end \
end
module program_space_data_access_tb;
  reg         mclk, arst_n, psel, penable, pwrite, req, byte_mode, is_write;
  reg         is_mov, in_repeat, rpt_first, rpt_last, rpt_irq_exit;
  reg         rpt_reentry;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [2:0]  op;
  reg  [15:0] effective_address, wdata;
  reg  [23:0] pc;
  wire [31:0] prdata;
  wire        pready, pslverr, done, addr_trap, data_sel, flash_req;
  wire        flash_we, flash_cfg, dmem_req;
  wire [23:0] pc_next, flash_addr, flash_wdata, flash_rdata;
  wire [15:0] rdata, dmem_addr;
  wire [1:0]  extra_cycles;
  wire [2:0]  flash_be;
  logic [33:0] q[$];
  logic [32:0] aq[$];
  int          num_errors = 0, checks = 0, cyc = 0, i;
  logic [31:0] r, w;
  logic [23:0] p;
  psda_top DUT (.*);
  psda_flash_model u_flash (.*);
  function [23:0] pat(input [23:0] a);
    pat = a ^ {a[15:0], a[23:16]} ^ 24'h5A3C96;
  endfunction
  function [33:0] ex(input t, input [15:0] d);
    ex = {17'h1FFFF, t, d};
  endfunction
  function [33:0] nx(input t);
    nx = {17'h10000, t, 16'h0000};
  endfunction
  task summarize;
    begin
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task apb(input bit wr, input [11:0] a, input [31:0] d, input [32:0] e);
    int n;
    begin
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      if (!wr) aq.push_back(e);
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rq(input [2:0] o, input bm, input wr, input [15:0] ea,
          input [15:0] wd, input [33:0] e);
    int n;
    begin
      @(posedge mclk);
      {op, byte_mode, is_write, effective_address, wdata} <= {o, bm, wr, ea, wd};
      {is_mov, in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_reentry}
        <= $urandom;
      req <= 1'b1;
      q.push_back(e);
      @(posedge mclk);
      req <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin @(posedge mclk); n++; end
      if (n >= 20) num_errors++;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    pc <= $urandom;
    cyc++;
    if (cyc == 5000) begin num_errors++; summarize(); end
    if (done === 1'b1) begin
      if (q.size() == 0) num_errors++;
      else `CHK({addr_trap, rdata} & q[0][33:17], q[0][16:0])
      if (q.size() > 0) void'(q.pop_front());
    end
    if (pready === 1'b1 && psel && penable && !pwrite && aq.size() > 0)
      `CHK({pslverr, prdata}, aq.pop_front())
  end
  initial begin
    {psel, penable, pwrite, req, byte_mode, is_write, is_mov} = 7'h00;
    {in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_reentry} = 5'h00;
    {paddr, pwdata, op, effective_address, wdata, pc} = 0;
    arst_n = 1'b0;
    void'($urandom(99));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 0; i < 3; i++) apb(1'b0, 12'h004 * i, 0, 33'h0);
    apb(1'b0, 12'h014, 0, {1'b1, 32'h0});
    apb(1'b1, `PSDA_OFF_TBLPG, 32'h12, 0);
    apb(1'b0, `PSDA_OFF_TBLPG, 0, 33'h12);
    r = $urandom;
    w = $urandom;
    p = pat({8'h12, r[15:1], 1'b0});
    rq(`PSDA_OP_RDL, 0, 0, r[15:0], 0, ex(0, p[15:0]));
    rq(`PSDA_OP_RDH, 0, 0, r[15:0], 0, ex(0, {8'h00, p[23:16]}));
    for (i = 0; i < 2; i++) begin
      rq(`PSDA_OP_RDL, 1, 0, {r[15:1], i[0]}, 0,
         {17'h100FF, 9'h000, i[0] ? p[15:8] : p[7:0]});
      rq(`PSDA_OP_RDH, 1, 0, {r[15:1], i[0]}, 0,
         {17'h100FF, 9'h000, i[0] ? 8'h00 : p[23:16]});
    end
    rq(`PSDA_OP_WTL, 0, 0, r[15:0], w[15:0], nx(0));
    rq(`PSDA_OP_RDL, 0, 0, r[15:0], 0, ex(0, w[15:0]));
    rq(`PSDA_OP_WTH, 0, 0, r[15:0], w[15:0], nx(0));
    rq(`PSDA_OP_RDH, 0, 0, r[15:0], 0, ex(0, {8'h00, w[7:0]}));
    apb(1'b1, `PSDA_OFF_TBLPG, 32'h92, 0);
    p = pat({8'h92, r[15:1], 1'b0});
    rq(`PSDA_OP_WTL, 0, 0, r[15:0], ~w[15:0], nx(0));
    rq(`PSDA_OP_RDL, 0, 0, r[15:0], 0, ex(0, p[15:0]));
    apb(1'b1, `PSDA_OFF_WRPG, 32'h201, 0);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `PSDA_OFF_RDPG, i[0] ? 32'h3A5 : 32'h2A5, 0);
      r = $urandom;
      p = pat({1'b0, 8'hA5, r[14:1], 1'b0});
      rq(`PSDA_OP_DATA, 0, 0, {1'b1, r[14:0]}, 0,
         ex(0, i[0] ? {8'h00, p[23:16]} : p[15:0]));
      rq(`PSDA_OP_DATA, 0, 1, {1'b1, r[14:0]}, r[31:16], nx(0));
      rq(`PSDA_OP_DATA, 0, 0, {1'b0, r[14:0]}, 0, nx(0));
    end
    apb(1'b1, `PSDA_OFF_RDPG, 0, 0);
    apb(1'b1, `PSDA_OFF_WRPG, 0, 0);
    rq(`PSDA_OP_DATA, 0, 0, {1'b1, r[14:0]}, 0, nx(1));
    rq(`PSDA_OP_DATA, 0, 1, {1'b1, r[14:0]}, w[15:0], nx(1));
    apb(1'b0, `PSDA_OFF_STATUS, 0, {1'b0, 32'h00010002});
    apb(1'b0, `PSDA_OFF_ADDRCNT, 0, {1'b0, 32'h00000011});
    repeat (4) @(posedge mclk);
    if (q.size() != 0 || aq.size() != 0) num_errors++;
    summarize();
  end
endmodule
